// ===== hw/core_decoder_regs.vh
// Purpose: shared constants for the instruction decoder core
// Assumes: included by bare name from every design file
// Notes: offsets are byte addresses on the debug register port
`ifndef CORE_DECODER_REGS_VH
`define CORE_DECODER_REGS_VH

// Oscillator periods per instruction cycle
`define INSN_CYCLE_PHASES 4
`define INSN_WIDTH 14
`define NOP_WORD 14'h0000

// Instruction classes, top two opcode bits
`define CLS_BYTE 2'h0
`define CLS_BIT 2'h1
`define CLS_JUMP 2'h2
`define CLS_LIT 2'h3

// Control words in the 0000 byte group (low seven bits)
`define CTL_RETURN 7'h08
`define CTL_INT_RETURN 7'h09
`define CTL_STANDBY 7'h63
`define CTL_WDT_CLEAR 7'h64

// ALU operations
`define ALU_PASS 4'h0
`define ALU_ADD 4'h1
`define ALU_SUB 4'h2
`define ALU_AND 4'h3
`define ALU_OR 4'h4
`define ALU_XOR 4'h5
`define ALU_COM 4'h6
`define ALU_DEC 4'h7
`define ALU_INC 4'h8
`define ALU_RL 4'h9
`define ALU_RR 4'ha
`define ALU_SWAP 4'hb
`define ALU_CLR 4'hc
`define ALU_BCLR 4'hd
`define ALU_BSET 4'he
`define ALU_LOADW 4'hf

// Special file register addresses
`define PORT_FILE_ADDR 7'h05
`define TIMER_FILE_ADDR 7'h01

// Debug register port
`define REG_CTRL 4'h0
`define REG_STATUS 4'h4
`define REG_ACCUM 4'h8
`define REG_PC 4'hc
`define CTRL_RUN_BIT 0
`define CTRL_RESET 16'h0001
`define ST_C 0
`define ST_DC 1
`define ST_Z 2
`define ST_POWERDOWN 3
`define ST_TIMEOUT 4
`define ST_SLEEP 5

`define STACK_DEPTH 8
`define PC_WIDTH 12
`endif

// ===== hw/decode_alu.v
// Purpose: 8-bit arithmetic and logic unit with status flag results
// Assumes: purely combinational, operands stable during the execute phase
// Notes: subtraction flags follow carry = no borrow
`include "core_decoder_regs.vh"
module decode_alu (
  input wire [3:0] op,
  input wire [7:0] a,
  input wire [7:0] w,
  input wire [2:0] bsel,
  input wire c_in,
  output reg [7:0] result,
  output reg c_out,
  output reg dc_out,
  output wire z_out
);
  // Returns {carry, digit carry, sum}
  function [9:0] add_flags;
    input [7:0] x;
    input [7:0] y;
    input cin;
    reg [4:0] lo;
    reg [8:0] full;
    begin
      lo = {1'b0, x[3:0]} + {1'b0, y[3:0]} + {4'h0, cin};
      full = {1'b0, x} + {1'b0, y} + {8'h00, cin};
      add_flags = {full[8], lo[4], full[7:0]};
    end
  endfunction

  wire [7:0] mask = 8'h01 << bsel;
  reg [9:0] sum;

  always @* begin
    sum = 10'h000;
    result = a;
    c_out = c_in;
    dc_out = 1'b0;
    case (op)
      `ALU_ADD: begin
        sum = add_flags(a, w, 1'b0);
        result = sum[7:0];
        c_out = sum[9];
        dc_out = sum[8];
      end
      `ALU_SUB: begin
        sum = add_flags(a, ~w, 1'b1);
        result = sum[7:0];
        c_out = sum[9];
        dc_out = sum[8];
      end
      `ALU_AND: result = a & w;
      `ALU_OR: result = a | w;
      `ALU_XOR: result = a ^ w;
      `ALU_COM: result = ~a;
      `ALU_DEC: result = a - 8'h01;
      `ALU_INC: result = a + 8'h01;
      `ALU_RL: begin
        result = {a[6:0], c_in};
        c_out = a[7];
      end
      `ALU_RR: begin
        result = {c_in, a[7:1]};
        c_out = a[0];
      end
      `ALU_SWAP: result = {a[3:0], a[7:4]};
      `ALU_CLR: result = 8'h00;
      `ALU_BCLR: result = a & ~mask;
      `ALU_BSET: result = a | mask;
      `ALU_LOADW: result = w;
      default: result = a;
    endcase
  end

  assign z_out = (result == 8'h00);
endmodule

// ===== hw/return_stack.v
// Purpose: hardware return address stack for call and return
// Assumes: push and pop never asserted together
// Notes: wraps silently on overflow, oldest entry is overwritten
`include "core_decoder_regs.vh"
module return_stack #(
  parameter DEPTH = `STACK_DEPTH,
  parameter PTR_W = 3,
  parameter AW = `PC_WIDTH
) (
  input wire clk,
  input wire rst_n,
  input wire push,
  input wire pop,
  input wire [AW-1:0] push_data,
  output wire [AW-1:0] top
);
  reg [AW-1:0] mem [0:DEPTH-1];
  reg [PTR_W-1:0] ptr_reg;
  wire [PTR_W-1:0] prev_ptr = ptr_reg - {{(PTR_W-1){1'b0}}, 1'b1};

  assign top = mem[prev_ptr];

  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      ptr_reg <= {PTR_W{1'b0}};
    end else if (push) begin
      ptr_reg <= ptr_reg + {{(PTR_W-1){1'b0}}, 1'b1};
    end else if (pop) begin
      ptr_reg <= prev_ptr;
    end
  end

  // Storage needs no reset; pointer alone defines contents
  always @(posedge clk) begin
    if (push) begin
      mem[ptr_reg] <= push_data;
    end
  end
endmodule

// ===== hw/core_instruction_decoder.v
// Purpose: fetch, decode and execute 14-bit instruction words
// Assumes: prog_data and file_rdata valid in the cycle their address is shown
// Notes: one instruction cycle is four clk periods; two-cycle forms add an idle cycle
//
// Overview of operation
// - File instructions always read before writing
// - Port read clears pin change condition
// - File address is low seven opcode bits
// - Bit 7 picks accumulator or file destination
// - Bit ops: prefix 01, bit field, action
// - True bit test skips next, two cycles
// - Add, subtract, logic decode with flag updates
// - Rotates go through carry, carry only
// - Increment/decrement skip forms skip on zero, no flags
// - Literal group decodes logic, add, sub, moves
// - Literal minus accumulator updates three flags
// - Return literal loads accumulator, two cycles
// - Standby and watchdog clear set timeout flags
// - PC changes and true tests cost two cycles
// - Port operand comes from pin levels
// - Timer write clears assigned prescaler
// - Don't care opcode bits are ignored
// - Instruction cycle is four oscillator periods
// - Literals: 8 bits data, 11 bits jumps
`include "core_decoder_regs.vh"
module core_instruction_decoder #(
  parameter PC_W = `PC_WIDTH,
  parameter STACK_DEPTH = `STACK_DEPTH,
  parameter STACK_PTR_W = 3,
  parameter [6:0] PORT_ADDR = `PORT_FILE_ADDR,
  parameter [6:0] TIMER_ADDR = `TIMER_FILE_ADDR
) (
  input wire clk,
  input wire rst_n,
  output wire [PC_W-1:0] prog_addr,
  input wire [13:0] prog_data,
  input wire [PC_W-12:0] page_bits,
  output wire [6:0] file_addr,
  output wire file_rd,
  input wire [7:0] file_rdata,
  output wire file_wr,
  output wire [7:0] file_wdata,
  input wire [7:0] port_pins,
  output wire pin_change_clear,
  input wire prescaler_on_timer,
  output wire prescaler_clear,
  input wire wake_event,
  output wire watchdog_clear,
  output wire sleep_enter,
  output wire interrupt_enable_set,
  output wire [7:0] accum,
  output wire carry_flag,
  output wire digit_carry_flag,
  output wire zero_flag,
  output wire timeout_flag,
  output wire powerdown_flag,
  input wire [3:0] reg_addr,
  input wire [15:0] reg_wdata,
  input wire reg_wr,
  input wire reg_rd,
  output wire [15:0] reg_rdata
);
  localparam PHASES = `INSN_CYCLE_PHASES;
  localparam [PHASES-1:0] PH_FETCH = 4'b0001;
  localparam [PHASES-1:0] PH_READ = 4'b0010;
  localparam [PHASES-1:0] PH_EXEC = 4'b0100;
  localparam [PHASES-1:0] PH_WRITE = 4'b1000;

  reg [PHASES-1:0] phase_reg;
  reg [13:0] ir_reg;
  reg [PC_W-1:0] program_counter_reg;
  reg [7:0] operand_reg;
  reg [7:0] result_reg;
  reg [7:0] accum_reg;
  reg alu_c_reg;
  reg alu_dc_reg;
  reg alu_z_reg;
  reg carry_reg;
  reg dc_reg;
  reg zero_reg;
  reg timeout_reg;
  reg powerdown_reg;
  reg sleep_reg;
  reg idle_next_reg;
  reg [15:0] ctrl_reg;
  reg [15:0] rdata_reg;

  // Decode outputs
  reg [3:0] alu_op;
  reg uses_file;
  reg wr_file;
  reg wr_w;
  reg use_lit;
  reg upd_c;
  reg upd_dc;
  reg upd_z;
  reg skip_zero;
  reg skip_bit_clr;
  reg skip_bit_set;
  reg is_jump;
  reg is_call;
  reg is_return;
  reg is_int_return;
  reg is_standby;
  reg is_wdt_clear;

  wire [7:0] alu_a;
  wire [7:0] alu_result;
  wire alu_c;
  wire alu_dc;
  wire alu_z;
  wire [PC_W-1:0] stack_top;
  wire [2:0] bit_sel = ir_reg[9:7];
  wire [PC_W-1:0] jump_target = {page_bits, ir_reg[10:0]};
  wire in_write = (phase_reg == PH_WRITE);
  wire running = ctrl_reg[`CTRL_RUN_BIT] & ~sleep_reg;
  wire test_true;
  wire two_cycle;

  // Decoder; every word maps to a defined action
  always @* begin
    alu_op = `ALU_PASS;
    uses_file = 1'b0;
    wr_file = 1'b0;
    wr_w = 1'b0;
    use_lit = 1'b0;
    upd_c = 1'b0;
    upd_dc = 1'b0;
    upd_z = 1'b0;
    skip_zero = 1'b0;
    skip_bit_clr = 1'b0;
    skip_bit_set = 1'b0;
    is_jump = 1'b0;
    is_call = 1'b0;
    is_return = 1'b0;
    is_int_return = 1'b0;
    is_standby = 1'b0;
    is_wdt_clear = 1'b0;
    case (ir_reg[13:12])
      `CLS_BYTE: begin
        uses_file = 1'b1;
        wr_file = ir_reg[7];
        wr_w = ~ir_reg[7];
        case (ir_reg[11:8])
          4'h0: begin
            if (ir_reg[7]) begin
              alu_op = `ALU_LOADW;
            end else begin
              uses_file = 1'b0;
              wr_w = 1'b0;
              // Bits 6:5 are don't care on the idle word
              if (ir_reg[4:0] != 5'h00) begin
                case (ir_reg[6:0])
                  `CTL_RETURN: is_return = 1'b1;
                  `CTL_INT_RETURN: is_int_return = 1'b1;
                  `CTL_STANDBY: is_standby = 1'b1;
                  `CTL_WDT_CLEAR: is_wdt_clear = 1'b1;
                  default: is_return = 1'b0;
                endcase
              end
            end
          end
          4'h1: begin
            alu_op = `ALU_CLR;
            upd_z = 1'b1;
            // Accumulator clear names no file; low bits ignored
            if (!ir_reg[7]) begin
              uses_file = 1'b0;
            end
          end
          4'h2: begin
            alu_op = `ALU_SUB;
            upd_c = 1'b1;
            upd_dc = 1'b1;
            upd_z = 1'b1;
          end
          4'h3: begin
            alu_op = `ALU_DEC;
            upd_z = 1'b1;
          end
          4'h4: begin
            alu_op = `ALU_OR;
            upd_z = 1'b1;
          end
          4'h5: begin
            alu_op = `ALU_AND;
            upd_z = 1'b1;
          end
          4'h6: begin
            alu_op = `ALU_XOR;
            upd_z = 1'b1;
          end
          4'h7: begin
            alu_op = `ALU_ADD;
            upd_c = 1'b1;
            upd_dc = 1'b1;
            upd_z = 1'b1;
          end
          4'h8: begin
            alu_op = `ALU_PASS;
            upd_z = 1'b1;
          end
          4'h9: begin
            alu_op = `ALU_COM;
            upd_z = 1'b1;
          end
          4'ha: begin
            alu_op = `ALU_INC;
            upd_z = 1'b1;
          end
          4'hb: begin
            alu_op = `ALU_DEC;
            skip_zero = 1'b1;
          end
          4'hc: begin
            alu_op = `ALU_RR;
            upd_c = 1'b1;
          end
          4'hd: begin
            alu_op = `ALU_RL;
            upd_c = 1'b1;
          end
          4'he: alu_op = `ALU_SWAP;
          4'hf: begin
            alu_op = `ALU_INC;
            skip_zero = 1'b1;
          end
          default: alu_op = `ALU_PASS;
        endcase
      end
      `CLS_BIT: begin
        uses_file = 1'b1;
        case (ir_reg[11:10])
          2'h0: begin
            alu_op = `ALU_BCLR;
            wr_file = 1'b1;
          end
          2'h1: begin
            alu_op = `ALU_BSET;
            wr_file = 1'b1;
          end
          2'h2: skip_bit_clr = 1'b1;
          2'h3: skip_bit_set = 1'b1;
          default: skip_bit_clr = 1'b0;
        endcase
      end
      `CLS_JUMP: begin
        is_jump = ir_reg[11];
        is_call = ~ir_reg[11];
      end
      `CLS_LIT: begin
        use_lit = 1'b1;
        wr_w = 1'b1;
        casez (ir_reg[11:8])
          4'b00??: alu_op = `ALU_PASS;
          4'b01??: begin
            alu_op = `ALU_PASS;
            is_return = 1'b1;
          end
          4'b1000: begin
            alu_op = `ALU_OR;
            upd_z = 1'b1;
          end
          4'b1001: begin
            alu_op = `ALU_AND;
            upd_z = 1'b1;
          end
          4'b1010: begin
            alu_op = `ALU_XOR;
            upd_z = 1'b1;
          end
          4'b110?: begin
            alu_op = `ALU_SUB;
            upd_c = 1'b1;
            upd_dc = 1'b1;
            upd_z = 1'b1;
          end
          4'b111?: begin
            alu_op = `ALU_ADD;
            upd_c = 1'b1;
            upd_dc = 1'b1;
            upd_z = 1'b1;
          end
          default: wr_w = 1'b0;
        endcase
      end
      default: alu_op = `ALU_PASS;
    endcase
  end

  // Literal minus accumulator: literal feeds the minuend side
  assign alu_a = use_lit ? ir_reg[7:0] : operand_reg;

  decode_alu alu_u (
    .op(alu_op),
    .a(alu_a),
    .w(accum_reg),
    .bsel(bit_sel),
    .c_in(carry_reg),
    .result(alu_result),
    .c_out(alu_c),
    .dc_out(alu_dc),
    .z_out(alu_z)
  );

  return_stack #(
    .DEPTH(STACK_DEPTH),
    .PTR_W(STACK_PTR_W),
    .AW(PC_W)
  ) stack_u (
    .clk(clk),
    .rst_n(rst_n),
    .push(in_write & is_call),
    .pop(in_write & (is_return | is_int_return)),
    .push_data(program_counter_reg),
    .top(stack_top)
  );

  assign test_true = (skip_zero & alu_z_reg)
    | (skip_bit_clr & ~operand_reg[bit_sel])
    | (skip_bit_set & operand_reg[bit_sel]);
  assign two_cycle = test_true | is_jump | is_call | is_return | is_int_return;

  // Four phases per instruction cycle
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      phase_reg <= PH_FETCH;
    end else begin
      case (phase_reg)
        PH_FETCH: begin
          if (running) begin
            phase_reg <= PH_READ;
          end
        end
        PH_READ: phase_reg <= PH_EXEC;
        PH_EXEC: phase_reg <= PH_WRITE;
        PH_WRITE: phase_reg <= PH_FETCH;
        default: phase_reg <= PH_FETCH;
      endcase
    end
  end

  // Fetch and sequencing
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      ir_reg <= `NOP_WORD;
      program_counter_reg <= {PC_W{1'b0}};
      idle_next_reg <= 1'b0;
    end else if (phase_reg == PH_FETCH && running) begin
      idle_next_reg <= 1'b0;
      // Second cycle of a two-cycle form fetches nothing
      if (idle_next_reg) begin
        ir_reg <= `NOP_WORD;
      end else begin
        ir_reg <= prog_data;
        program_counter_reg <= program_counter_reg + {{(PC_W-1){1'b0}}, 1'b1};
      end
    end else if (in_write) begin
      idle_next_reg <= two_cycle;
      if (is_jump | is_call) begin
        program_counter_reg <= jump_target;
      end else if (is_return | is_int_return) begin
        program_counter_reg <= stack_top;
      end else if (test_true) begin
        // Skipped word is passed over, not executed
        program_counter_reg <= program_counter_reg + {{(PC_W-1){1'b0}}, 1'b1};
      end
    end
  end

  // Operand capture and execute
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      operand_reg <= 8'h00;
      result_reg <= 8'h00;
      alu_c_reg <= 1'b0;
      alu_dc_reg <= 1'b0;
      alu_z_reg <= 1'b0;
    end else if (phase_reg == PH_READ) begin
      // Port reads see pin levels, not the output latch
      if (file_addr == PORT_ADDR) begin
        operand_reg <= port_pins;
      end else begin
        operand_reg <= file_rdata;
      end
    end else if (phase_reg == PH_EXEC) begin
      result_reg <= alu_result;
      alu_c_reg <= alu_c;
      alu_dc_reg <= alu_dc;
      alu_z_reg <= alu_z;
    end
  end

  // Accumulator and status flags
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      accum_reg <= 8'h00;
      carry_reg <= 1'b0;
      dc_reg <= 1'b0;
      zero_reg <= 1'b0;
      timeout_reg <= 1'b1;
      powerdown_reg <= 1'b1;
    end else if (in_write) begin
      if (wr_w) begin
        accum_reg <= result_reg;
      end
      if (upd_c) begin
        carry_reg <= alu_c_reg;
      end
      if (upd_dc) begin
        dc_reg <= alu_dc_reg;
      end
      if (upd_z) begin
        zero_reg <= alu_z_reg;
      end
      if (is_standby) begin
        timeout_reg <= 1'b1;
        powerdown_reg <= 1'b0;
      end else if (is_wdt_clear) begin
        timeout_reg <= 1'b1;
        powerdown_reg <= 1'b1;
      end
    end
  end

  // Standby holds fetch until a wake event; entry wins over wake
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      sleep_reg <= 1'b0;
    end else if (in_write && is_standby) begin
      sleep_reg <= 1'b1;
    end else if (wake_event) begin
      sleep_reg <= 1'b0;
    end
  end

  assign prog_addr = program_counter_reg;
  assign file_addr = ir_reg[6:0];
  assign file_rd = (phase_reg == PH_READ) & uses_file;
  assign file_wr = in_write & wr_file;
  assign file_wdata = result_reg;
  // Any read of the port, even by a clear, ends the change condition
  assign pin_change_clear = file_rd & (file_addr == PORT_ADDR);
  assign prescaler_clear = file_wr & (file_addr == TIMER_ADDR) & prescaler_on_timer;
  assign watchdog_clear = in_write & is_wdt_clear;
  assign sleep_enter = in_write & is_standby;
  assign interrupt_enable_set = in_write & is_int_return;
  assign accum = accum_reg;
  assign carry_flag = carry_reg;
  assign digit_carry_flag = dc_reg;
  assign zero_flag = zero_reg;
  assign timeout_flag = timeout_reg;
  assign powerdown_flag = powerdown_reg;

  // Debug register port
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      ctrl_reg <= `CTRL_RESET;
    end else if (reg_wr && reg_addr == `REG_CTRL) begin
      ctrl_reg <= {15'h0000, reg_wdata[`CTRL_RUN_BIT]};
    end
  end

  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rdata_reg <= 16'h0000;
    end else if (reg_rd) begin
      case (reg_addr)
        `REG_CTRL: rdata_reg <= ctrl_reg;
        `REG_STATUS: rdata_reg <= {10'h000, sleep_reg, timeout_reg, powerdown_reg,
          zero_reg, dc_reg, carry_reg};
        `REG_ACCUM: rdata_reg <= {8'h00, accum_reg};
        `REG_PC: rdata_reg <= {{(16-PC_W){1'b0}}, program_counter_reg};
        default: rdata_reg <= 16'h0000;
      endcase
    end else begin
      // Data stands only in the cycle after the read strobe
      rdata_reg <= 16'h0000;
    end
  end

  assign reg_rdata = rdata_reg;
endmodule

// ===== test/decoder_properties.sv
// Purpose: port-level properties of the instruction decoder
// Assumes: bound to core_instruction_decoder, one clock domain
// Notes: watches file bus pulses and flag updates only
module decoder_checker #(
  parameter [6:0] PORT_ADDR = 7'h05,
  parameter [6:0] TIMER_ADDR = 7'h01
) (
  input wire clk,
  input wire rst_n,
  input wire [6:0] file_addr,
  input wire file_rd,
  input wire file_wr,
  input wire pin_change_clear,
  input wire prescaler_on_timer,
  input wire prescaler_clear,
  input wire watchdog_clear,
  input wire sleep_enter,
  input wire timeout_flag,
  input wire powerdown_flag
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);
  a_read_before_write: assert property (file_wr |-> $past(file_rd, 2))
    else $error("file write without earlier read");
  a_addr_held: assert property (file_rd |=> $stable(file_addr) [*2])
    else $error("file address moved mid instruction");
  a_port_clear: assert property (pin_change_clear == (file_rd && file_addr == PORT_ADDR))
    else $error("pin change clear mismatch");
  a_port_write_read: assert property (file_wr && file_addr == PORT_ADDR |->
    $past(pin_change_clear, 2))
    else $error("port written without clearing pin change");
  a_prescaler_clear: assert property (prescaler_clear ==
    (file_wr && file_addr == TIMER_ADDR && prescaler_on_timer))
    else $error("prescaler clear mismatch");
  a_write_spacing: assert property (file_wr |=> !file_wr [*3])
    else $error("two writes in one instruction cycle");
  a_read_spacing: assert property (file_rd |=> !file_rd [*3])
    else $error("two reads in one instruction cycle");
  a_wdt_flags: assert property (watchdog_clear |=> timeout_flag && powerdown_flag)
    else $error("watchdog clear flags wrong");
  a_sleep_flags: assert property (sleep_enter |=> timeout_flag && !powerdown_flag)
    else $error("standby flags wrong");
endmodule

// ===== test/tb_top.sv
// Purpose: self-checking bench for the instruction decoder
// Assumes: program and file memories modelled here, read combinationally
// Notes: each program ends in a jump to itself; results read over the register port
module tb_top;
  timeunit 1ns;
  timeprecision 100ps;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic [11:0] prog_addr;
  logic [13:0] prog_data;
  logic [6:0] file_addr;
  logic file_rd, file_wr, pin_change_clear, prescaler_clear;
  logic [7:0] file_wdata;
  logic [7:0] port_pins = 8'ha5;
  logic prescaler_on_timer = 1'b1;
  logic wake_event = 1'b0;
  logic [3:0] reg_addr = 4'h0;
  logic [15:0] reg_wdata = 16'h0000;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic [15:0] reg_rdata;
  logic [7:0] accum;
  logic irq_set;
  logic [13:0] rom [0:15];
  logic [7:0] fmem [0:127];
  integer errors = 0;
  integer check_count = 0;
  integer n_pin, n_pre, n_ret;

  initial begin
    forever #5 clk = ~clk;
  end

  core_instruction_decoder dut (.clk(clk), .rst_n(rst_n), .prog_addr(prog_addr),
    .prog_data(prog_data), .page_bits(1'b0), .file_addr(file_addr), .file_rd(file_rd),
    .file_rdata(fmem[file_addr]), .file_wr(file_wr), .file_wdata(file_wdata),
    .port_pins(port_pins), .pin_change_clear(pin_change_clear),
    .prescaler_on_timer(prescaler_on_timer), .prescaler_clear(prescaler_clear),
    .wake_event(wake_event), .watchdog_clear(), .sleep_enter(), .interrupt_enable_set(irq_set),
    .accum(accum), .carry_flag(), .digit_carry_flag(), .zero_flag(), .timeout_flag(),
    .powerdown_flag(), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_rdata(reg_rdata));

  assign prog_data = rom[prog_addr[3:0]];

  // File memory write port and pulse counters
  always @(posedge clk) begin
    if (file_wr === 1'b1) begin
      fmem[file_addr] <= file_wdata;
    end
    if (!rst_n) begin
      n_pin <= 0;
      n_pre <= 0;
      n_ret <= 0;
    end else begin
      n_pin <= n_pin + (pin_change_clear === 1'b1);
      n_pre <= n_pre + (prescaler_clear === 1'b1);
      n_ret <= n_ret + (irq_set === 1'b1);
    end
  end

  task automatic report_and_stop;
    $display("checks %0d errors %0d", check_count, errors);
    if (errors == 0 && check_count > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask

  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    check_count = check_count + 1;
    if (seen !== exp) begin
      errors = errors + 1;
      $display("unexpected at %0t: got %h want %h", $time, seen, exp);
    end
  endtask

  task automatic rd(input logic [3:0] a, input logic [15:0] exp);
    @(posedge clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge clk);
    reg_rd <= 1'b0;
    #1 check(reg_rdata, exp);
  endtask

  task automatic wr(input logic [3:0] a, input logic [15:0] d);
    @(posedge clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge clk);
    reg_wr <= 1'b0;
  endtask

  // Resets, runs until prog_addr shows the stop address, lets the last words finish
  task automatic run(input logic [11:0] stop);
    integer i;
    @(posedge clk);
    rst_n <= 1'b0;
    repeat (8) @(posedge clk);
    rst_n <= 1'b1;
    for (i = 0; i < 400 && prog_addr !== stop; i = i + 1) begin
      @(posedge clk) #1;
    end
    if (i == 400) begin
      errors = errors + 1;
      report_and_stop;
    end
    repeat (12) @(posedge clk);
  endtask

  initial begin
    // Byte ops, destination bit, top file address
    rom = '{0:14'h300f, 1:14'h00a0, 2:14'h00ff, 3:14'h3001, 4:14'h07a0, 5:14'h0620,
      6:14'h2806, default:14'h0000};
    run(12'h006);
    rd(4'h8, 16'h0011);
    rd(4'h4, 16'h001a);
    check(fmem[7'h20], 16'h0010);
    check(fmem[7'h7f], 16'h000f);
    check(n_pin, 16'h0000);
    rd(4'h0, 16'h0001);
    rd(4'h2, 16'h0000);
    wr(4'h0, 16'h0000);
    rd(4'h0, 16'h0000);
    // Skips taken and not taken, no flags touched
    rom = '{0:14'h3001, 1:14'h00a1, 2:14'h0ba1, 3:14'h3055, 4:14'h1c21, 5:14'h30aa,
      6:14'h19a1, 7:14'h3077, 8:14'h2808, default:14'h0000};
    run(12'h008);
    rd(4'h8, 16'h00aa);
    rd(4'h4, 16'h0018);
    check(fmem[7'h21], 16'h0000);
    // Literal group, call and return, unlisted word, loose bits set
    rom = '{0:14'h3310, 1:14'h200a, 2:14'h3d05, 3:14'h380a, 4:14'h3f31, 5:14'h3a3c,
      6:14'h39c3, 7:14'h3bff, 8:14'h0064, 9:14'h2809, 10:14'h3740, default:14'h0000};
    run(12'h009);
    rd(4'h8, 16'h0000);
    rd(4'h4, 16'h001f);
    // Port from pins, rotates, timer clear, skip on zero, standby then wake
    fmem[7'h05] = 8'hff;
    fmem[7'h22] = 8'h02;
    fmem[7'h23] = 8'hff;
    fmem[7'h01] = 8'h37;
    rom = '{0:14'h0d85, 1:14'h0c22, 2:14'h0181, 3:14'h0fa3, 4:14'h3099, 5:14'h0063,
      6:14'h2806, default:14'h0000};
    run(12'h006);
    check(fmem[7'h05], 16'h004a);
    rd(4'h8, 16'h0081);
    check(fmem[7'h01], 16'h0000);
    check(fmem[7'h23], 16'h0000);
    check(n_pin, 16'h0001);
    check(n_pre, 16'h0001);
    rd(4'h4, 16'h0034);
    @(posedge clk);
    wake_event <= 1'b1;
    @(posedge clk);
    wake_event <= 1'b0;
    repeat (8) @(posedge clk);
    rd(4'h4, 16'h0014);
    // Two calls in turn, both returns, swap, bit set; word 6 stays a loop so the old run is harmless
    prescaler_on_timer <= 1'b0;
    rom = '{0:14'h2007, 1:14'h200b, 2:14'h0ea0, 3:14'h2806, 6:14'h2806, 7:14'h3007,
      8:14'h0222, 9:14'h0081, 10:14'h0009, 11:14'h17a2, 12:14'h0008, default:14'h0000};
    run(12'h006);
    check(accum, 16'h00fb);
    rd(4'h4, 16'h0018);
    check(fmem[7'h20], 16'h0001);
    check(fmem[7'h22], 16'h0082);
    check(fmem[7'h01], 16'h00fb);
    check(n_pre, 16'h0000);
    check(n_ret, 16'h0001);
    report_and_stop;
  end
endmodule

bind core_instruction_decoder decoder_checker #(.PORT_ADDR(PORT_ADDR),
  .TIMER_ADDR(TIMER_ADDR)) chk (.clk(clk), .rst_n(rst_n), .file_addr(file_addr),
  .file_rd(file_rd), .file_wr(file_wr), .pin_change_clear(pin_change_clear),
  .prescaler_on_timer(prescaler_on_timer), .prescaler_clear(prescaler_clear),
  .watchdog_clear(watchdog_clear), .sleep_enter(sleep_enter),
  .timeout_flag(timeout_flag), .powerdown_flag(powerdown_flag));
